/* File: group_buffer.sv */
// small valid/ready buffer for queued symbol groups
`timescale 1ns/1ps
`default_nettype none
module group_buffer #(
  parameter int WIDTH = ser_pkg::BUF_WIDTH,
  parameter int DEPTH = ser_pkg::BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd_idx;
    logic [CW-1:0] cnt;
  } buf_state_t;

  buf_state_t s_r;
  buf_state_t s_nxt;
  logic push;
  logic pop;
  logic [AW-1:0] wr_idx;

  // depth is a power of two, so the write index wraps by truncation
  always_comb
  begin
    s_nxt = s_r;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_idx = AW'(s_r.rd_idx + AW'(s_r.cnt));
    if (push)
      s_nxt.mem[wr_idx] = in_data;
    if (pop)
      s_nxt.rd_idx = AW'(s_r.rd_idx + AW'(1));
    if (push && !pop)
      s_nxt.cnt = CW'(s_r.cnt + CW'(1));
    else if (pop && !push)
      s_nxt.cnt = CW'(s_r.cnt - CW'(1));
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // honest full and empty
  assign in_ready = (s_r.cnt != CW'(DEPTH));
  assign out_valid = (s_r.cnt != CW'(0));
  assign out_data = s_r.mem[s_r.rd_idx];
endmodule : group_buffer
`default_nettype wire

/* File: rf_front_end_model.sv */
// passive model of amplifier, synthesizer and oscillator at the rf pins
`timescale 1ns/1ps
`default_nettype none
module rf_front_end_model (
  input wire logic clk_sys,
  input wire logic pa_ena,
  input wire logic [3:0] pa_ramp_level,
  input wire logic mpll_ena,
  input wire logic lc_ena,
  input wire logic tx_symbol
);
  int cyc = 0;
  int t_pll = 0;
  int t_pa = 0;
  int t_edge = 0;
  int warm_span = 0;
  int pa_to_tx = 0;
  int sym_gap = 0;
  int n_rise = 0;
  int bad = 0;
  logic [3:0] max_level = 4'h0;
  logic first = 1'b0;
  logic pll_q = 1'b0;
  logic pa_q = 1'b0;
  logic tx_q = 1'b0;
  // time stamps of power-up steps and symbol edges, in system clocks
  always @(negedge clk_sys)
  begin
    cyc++;
    if (mpll_ena && !pll_q) t_pll = cyc;
    if (pa_ena && !pa_q)
    begin
      warm_span = cyc - t_pll;
      t_pa = cyc;
      first = 1'b1;
    end
    if (tx_symbol !== tx_q)
    begin
      sym_gap = cyc - t_edge;
      t_edge = cyc;
    end
    if (tx_symbol && !tx_q)
    begin
      n_rise++;
      if (first) pa_to_tx = cyc - t_pa;
      first = 1'b0;
    end
    // amplifier without a locked synthesizer or oscillator would splatter
    if (pa_ena && !(mpll_ena && lc_ena)) bad++;
    if (pa_ramp_level > max_level) max_level = pa_ramp_level;
    pll_q = mpll_ena;
    pa_q = pa_ena;
    tx_q = tx_symbol;
  end
endmodule : rf_front_end_model
`default_nettype wire

/* File: rf_output_symbol_serializer.sv */
// symbol serializer with register file and rf power sequencing
`timescale 1ns/1ps
`default_nettype none
// Function
// - group width field plus one gives 1 to 8 symbols per group.
// - width may change between groups; new width applies to next written group.
// - edge time field plus one gives extra division factor 1 to 4.
// - pa ramps over eight times divider times edge factor reference periods.
// - serializer clock is 25 MHz reference divided by divider field plus one.
// - holding register keeps next group; a holding write clears the empty flag unless a hand-over sets it in the same cycle.
// - each holding write gives one registered new-data pulse with data stable.
// - rate value is 15 bits: low byte plus seven upper bits.
// - each symbol lasts five times rate value serializer clocks.
// - top bit of upper rate register reads zero, writes ignored.
// - synthesizer warms up for field times four serializer clocks.
// - amplifier warms up for field value serializer clocks.
// - groups shift out lsb first; unused upper bits never sent.
// - underrun policy: stop cleanly, repeat group, send zeros, or ones.
// - serializer starts only while the enable bit is set; once it is cleared, it stops after the current group.
// - modulation bit one selects fsk, otherwise ook.
module rf_output_symbol_serializer (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic new_data_pulse,
  output logic holding_empty,
  output logic tx_symbol,
  output logic tx_active,
  output logic fsk_select,
  output logic pa_ena,
  output logic [3:0] pa_ramp_level,
  output logic mpll_ena,
  output logic lc_ena
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] timing;
    logic [7:0] hold;
    logic [2:0] hold_w;
    logic [7:0] rate_lo;
    logic [6:0] rate_hi;
    logic [7:0] warm;
    logic [7:0] rdata;
    logic new_pulse;
    logic empty;
    logic pending;
    ser_pkg::seq_state_t state;
    logic [17:0] cnt;
    logic [2:0] edge_cnt;
    logic [3:0] level;
    logic [7:0] shreg;
    logic [2:0] bits_left;
    logic [7:0] last_grp;
    logic [2:0] last_w;
    logic o_sym;
    logic o_act;
    logic o_fsk;
    logic o_pa;
    logic [3:0] o_lvl;
    logic o_pll;
    logic o_lc;
  } ser_state_t;

  ser_state_t s_r;
  ser_state_t s_nxt;
  logic ref_tick;
  logic ser_tick;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [10:0] buf_out_data;
  logic pop;
  logic sym_end;
  logic load_en;
  logic [7:0] load_grp;
  logic [2:0] load_w;
  logic nxt_bit;
  logic en;
  logic fsk;
  logic [2:0] edge_lim;
  logic [2:0] serial_clock_divider;
  logic [3:0] amp_warmup_interval;
  logic [17:0] pll_lim;
  logic [17:0] sym_lim;
  logic pa_on;

  // cycles per symbol minus one, zero rate treated as one cycle
  function automatic logic [17:0] sym_limit(input logic [14:0] rate);
    logic [17:0] p;
    p = 18'(rate) * ser_pkg::SYM_CLKS_PER_RATE;
    return (p == 18'h00000) ? 18'h00000 : 18'(p - 18'h00001);
  endfunction : sym_limit

  tick_divider u_ref_div (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .en_in(1'b1),
    .limit(ser_pkg::REF_DIV_LIMIT),
    .tick(ref_tick)
  );
  tick_divider u_ser_div (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .en_in(ref_tick),
    .limit(serial_clock_divider),
    .tick(ser_tick)
  );

  // queued groups: width code above the byte
  group_buffer u_buf (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(s_r.pending),
    .in_data({s_r.hold_w, s_r.hold}),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_data(buf_out_data),
    .out_ready(pop)
  );

  // field decode
  assign en = s_r.ctrl[ser_pkg::CTRL_EN_BIT];
  assign fsk = s_r.ctrl[ser_pkg::CTRL_FSK_BIT];
  assign edge_lim = {1'b0, s_r.timing[ser_pkg::EDGE_LSB +: 2]};
  assign serial_clock_divider = s_r.timing[ser_pkg::DIV_LSB +: 3];
  assign amp_warmup_interval = s_r.warm[ser_pkg::PA_WARM_LSB +: 4];
  assign pll_lim = 18'(s_r.warm[ser_pkg::PLL_WARM_LSB +: 4]) << ser_pkg::PLL_WARM_SHIFT;
  assign sym_lim = sym_limit({s_r.rate_hi, s_r.rate_lo});

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.new_pulse = 1'b0;
    pop = 1'b0;
    sym_end = 1'b0;
    load_en = 1'b0;
    load_grp = 8'h00;
    load_w = 3'h0;
    nxt_bit = 1'b0;
    pa_on = 1'b0;
    // register writes
    if (sfr_wr)
    begin
      case (sfr_addr)
        ser_pkg::ADDR_CTRL: s_nxt.ctrl = sfr_wdata & ser_pkg::CTRL_MASK;
        ser_pkg::ADDR_TIMING: s_nxt.timing = sfr_wdata;
        ser_pkg::ADDR_HOLD:
        begin
          s_nxt.hold = sfr_wdata;
          s_nxt.empty = 1'b0;
          s_nxt.hold_w = s_r.timing[ser_pkg::GW_LSB +: 3];
          // pulse on the same edge that the data lands
          s_nxt.new_pulse = 1'b1;
        end
        ser_pkg::ADDR_RATE_LO: s_nxt.rate_lo = sfr_wdata;
        ser_pkg::ADDR_RATE_HI: s_nxt.rate_hi = sfr_wdata[6:0];
        ser_pkg::ADDR_WARM: s_nxt.warm = sfr_wdata;
        default: ;
      endcase
    end
    // register reads, unmapped addresses read zero
    if (sfr_rd)
    begin
      case (sfr_addr)
        ser_pkg::ADDR_CTRL: s_nxt.rdata = s_r.ctrl;
        ser_pkg::ADDR_TIMING: s_nxt.rdata = s_r.timing;
        ser_pkg::ADDR_HOLD: s_nxt.rdata = s_r.hold;
        ser_pkg::ADDR_RATE_LO: s_nxt.rdata = s_r.rate_lo;
        // upper seven rate bits, bit 7 zero
        ser_pkg::ADDR_RATE_HI: s_nxt.rdata = {1'b0, s_r.rate_hi} & ser_pkg::RATE_HI_MASK;
        ser_pkg::ADDR_WARM: s_nxt.rdata = s_r.warm;
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    // move the held group into the buffer, stalled while it is full
    if (s_r.pending && buf_in_ready)
      s_nxt.pending = 1'b0;
    if (s_r.new_pulse)
      s_nxt.pending = 1'b1;
    // power and shift sequencer
    case (s_r.state)
      ser_pkg::ST_IDLE:
      begin
        // start only when enabled, on a serializer clock edge
        // so that every warm-up interval spans whole ticks
        if (en && buf_out_valid && ser_tick)
        begin
          pop = 1'b1;
          load_en = 1'b1;
          load_grp = buf_out_data[7:0];
          load_w = buf_out_data[10:8];
          s_nxt.state = ser_pkg::ST_WARM_PLL;
          s_nxt.cnt = 18'h00000;
        end
      end
      ser_pkg::ST_WARM_PLL:
      begin
        // synthesizer warm-up, four clocks per step
        if (ser_tick)
        begin
          if (18'(s_r.cnt + 18'h00001) >= pll_lim)
          begin
            s_nxt.state = ser_pkg::ST_WARM_PA;
            s_nxt.cnt = 18'h00000;
          end
          else
            s_nxt.cnt = s_r.cnt + 18'h00001;
        end
      end
      ser_pkg::ST_WARM_PA:
      begin
        if (ser_tick)
        begin
          if (18'(s_r.cnt + 18'h00001) >= 18'(amp_warmup_interval))
          begin
            s_nxt.state = ser_pkg::ST_RAMP_UP;
            s_nxt.cnt = 18'h00000;
            s_nxt.edge_cnt = 3'h0;
            s_nxt.level = 4'h0;
          end
          else
            s_nxt.cnt = s_r.cnt + 18'h00001;
        end
      end
      ser_pkg::ST_RAMP_UP:
      begin
        // each step lasts edge factor serializer clocks
        if (ser_tick)
        begin
          if (s_r.edge_cnt >= edge_lim)
          begin
            s_nxt.edge_cnt = 3'h0;
            // eight steps up to full level
            s_nxt.level = s_r.level + 4'h1;
            if (s_nxt.level == ser_pkg::RAMP_STEPS)
            begin
              s_nxt.state = ser_pkg::ST_SEND;
              s_nxt.cnt = 18'h00000;
            end
          end
          else
            s_nxt.edge_cnt = s_r.edge_cnt + 3'h1;
        end
      end
      ser_pkg::ST_SEND:
      begin
        // symbol length is five times rate clocks
        if (ser_tick)
        begin
          if (s_r.cnt >= sym_lim)
          begin
            sym_end = 1'b1;
            s_nxt.cnt = 18'h00000;
          end
          else
            s_nxt.cnt = s_r.cnt + 18'h00001;
        end
        if (sym_end)
        begin
          if (s_r.bits_left != 3'h0)
          begin
            s_nxt.shreg = {1'b0, s_r.shreg[7:1]};
            s_nxt.bits_left = s_r.bits_left - 3'h1;
            nxt_bit = s_r.shreg[1];
          end
          else if (!en)
          begin
            s_nxt.state = ser_pkg::ST_RAMP_DOWN;
            s_nxt.edge_cnt = 3'h0;
          end
          else if (buf_out_valid)
          begin
            pop = 1'b1;
            load_en = 1'b1;
            load_grp = buf_out_data[7:0];
            load_w = buf_out_data[10:8];
            nxt_bit = buf_out_data[0];
          end
          else
          begin
            load_w = s_r.last_w;
            case (ser_pkg::underrun_t'(s_r.ctrl[ser_pkg::CTRL_UNDERRUN_LSB +: 2]))
              ser_pkg::UR_REPEAT: load_grp = s_r.last_grp;
              ser_pkg::UR_ZEROS: load_grp = 8'h00;
              ser_pkg::UR_ONES: load_grp = 8'hFF;
              default: load_grp = 8'h00;
            endcase
            if (s_r.ctrl[ser_pkg::CTRL_UNDERRUN_LSB +: 2] == ser_pkg::UR_STOP)
            begin
              s_nxt.state = ser_pkg::ST_RAMP_DOWN;
              s_nxt.edge_cnt = 3'h0;
            end
            else
            begin
              load_en = 1'b1;
              nxt_bit = load_grp[0];
            end
          end
          // ook re-warms rf on a zero-to-one step
          if (!fsk && (s_nxt.state == ser_pkg::ST_SEND) && !s_r.shreg[0] && nxt_bit)
          begin
            s_nxt.state = ser_pkg::ST_WARM_PLL;
            s_nxt.cnt = 18'h00000;
          end
        end
      end
      ser_pkg::ST_RAMP_DOWN:
      begin
        // ramp down with the same step time
        if (s_r.level == 4'h0)
          s_nxt.state = ser_pkg::ST_IDLE;
        else if (ser_tick)
        begin
          if (s_r.edge_cnt >= edge_lim)
          begin
            s_nxt.edge_cnt = 3'h0;
            s_nxt.level = s_r.level - 4'h1;
            if (s_r.level == 4'h1)
              s_nxt.state = ser_pkg::ST_IDLE;
          end
          else
            s_nxt.edge_cnt = s_r.edge_cnt + 3'h1;
        end
      end
      default: s_nxt.state = ser_pkg::ST_IDLE;
    endcase
    // group holds width code plus one symbols
    if (load_en)
    begin
      s_nxt.shreg = load_grp;
      s_nxt.bits_left = load_w;
      s_nxt.last_grp = load_grp;
      s_nxt.last_w = load_w;
    end
    // hand-over sets empty, winning over a write
    if (pop)
      s_nxt.empty = 1'b1;
    // registered outputs follow the next state
    case (s_nxt.state)
      ser_pkg::ST_SEND: pa_on = s_nxt.ctrl[ser_pkg::CTRL_FSK_BIT] || s_nxt.shreg[0];
      ser_pkg::ST_WARM_PA: pa_on = 1'b1;
      ser_pkg::ST_RAMP_UP: pa_on = 1'b1;
      ser_pkg::ST_RAMP_DOWN: pa_on = 1'b1;
      default: pa_on = 1'b0;
    endcase
    s_nxt.o_sym = (s_nxt.state == ser_pkg::ST_SEND) && s_nxt.shreg[0];
    s_nxt.o_act = (s_nxt.state != ser_pkg::ST_IDLE);
    s_nxt.o_fsk = s_nxt.ctrl[ser_pkg::CTRL_FSK_BIT];
    s_nxt.o_pa = pa_on || s_nxt.ctrl[ser_pkg::CTRL_FORCE_PA_BIT];
    s_nxt.o_lvl = s_nxt.o_pa ? s_nxt.level : 4'h0;
    s_nxt.o_pll = s_nxt.ctrl[ser_pkg::CTRL_FORCE_PLL_BIT]
      || ((s_nxt.state != ser_pkg::ST_IDLE) && (s_nxt.state != ser_pkg::ST_SEND || pa_on));
    s_nxt.o_lc = s_nxt.ctrl[ser_pkg::CTRL_FORCE_LC_BIT] || (s_nxt.state != ser_pkg::ST_IDLE);
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s_r <= '0;
      s_r.empty <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign sfr_rdata = s_r.rdata;
  assign new_data_pulse = s_r.new_pulse;
  assign holding_empty = s_r.empty;
  assign tx_symbol = s_r.o_sym;
  assign tx_active = s_r.o_act;
  assign fsk_select = s_r.o_fsk;
  assign pa_ena = s_r.o_pa;
  assign pa_ramp_level = s_r.o_lvl;
  assign mpll_ena = s_r.o_pll;
  assign lc_ena = s_r.o_lc;

  // checks
  sequence s_hold_write;
    sfr_wr && (sfr_addr == ser_pkg::ADDR_HOLD);
  endsequence
  sequence s_pulse_with_data;
    new_data_pulse && (s_r.hold == $past(sfr_wdata))
      ##1 (!new_data_pulse || $past(sfr_wr && (sfr_addr == ser_pkg::ADDR_HOLD)));
  endsequence
  property p_new_pulse;
    @(posedge clk_sys) disable iff (!resetn) s_hold_write |=> s_pulse_with_data;
  endproperty
  a_new_pulse: assert property (p_new_pulse) else $error("new-data pulse wrong");
  property p_empty_clear;
    @(posedge clk_sys) disable iff (!resetn) s_hold_write and !pop |=> !holding_empty;
  endproperty
  a_empty_clear: assert property (p_empty_clear) else $error("empty not cleared");
  property p_empty_set;
    @(posedge clk_sys) disable iff (!resetn) pop |=> holding_empty;
  endproperty
  a_empty_set: assert property (p_empty_set) else $error("empty not set on load");
  property p_rate_hi_read;
    @(posedge clk_sys) disable iff (!resetn)
      sfr_rd && (sfr_addr == ser_pkg::ADDR_RATE_HI) |=> !sfr_rdata[7];
  endproperty
  a_rate_hi_read: assert property (p_rate_hi_read) else $error("rate bit 7 not zero");
  property p_ref_tick;
    @(posedge clk_sys) disable iff (!resetn) ref_tick |=> !ref_tick ##1 ref_tick;
  endproperty
  a_ref_tick: assert property (p_ref_tick) else $error("reference tick spacing");
  property p_idle_hold;
    @(posedge clk_sys) disable iff (!resetn)
      (s_r.state == ser_pkg::ST_IDLE) && !en |=> !tx_active;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("started while disabled");
  property p_fsk_pa;
    @(posedge clk_sys) disable iff (!resetn)
      (s_r.state == ser_pkg::ST_SEND) && fsk_select |-> pa_ena && (pa_ramp_level == 4'h8);
  endproperty
  a_fsk_pa: assert property (p_fsk_pa) else $error("fsk send without full pa");
  property p_lsb_first;
    @(posedge clk_sys) disable iff (!resetn)
      sym_end && (s_r.bits_left != 3'h0) && (fsk || s_r.shreg[0] || !s_r.shreg[1])
      |=> tx_symbol == $past(s_r.shreg[1]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("shift order wrong");
  property p_pll_warm;
    @(posedge clk_sys) disable iff (!resetn)
      (s_r.state == ser_pkg::ST_WARM_PLL) && ser_tick && (pll_lim != 18'h00000)
      && (s_r.cnt == 18'(pll_lim - 18'h00001))
      |=> s_r.state == ser_pkg::ST_WARM_PA;
  endproperty
  a_pll_warm: assert property (p_pll_warm) else $error("pll warm-up length");
  property p_sym_count;
    @(posedge clk_sys) disable iff (!resetn)
      (s_r.state == ser_pkg::ST_SEND) && ser_tick && (s_r.cnt < sym_lim)
      |=> s_r.cnt == $past(s_r.cnt) + 18'h00001;
  endproperty
  a_sym_count: assert property (p_sym_count) else $error("symbol counter");
endmodule : rf_output_symbol_serializer
`default_nettype wire

/* File: ser_pkg.sv */
// constants, register map and types shared by the symbol serializer
package ser_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CTRL = 8'hA9;
  localparam logic [7:0] ADDR_TIMING = 8'hAA;
  localparam logic [7:0] ADDR_HOLD = 8'hAB;
  localparam logic [7:0] ADDR_RATE_LO = 8'hAC;
  localparam logic [7:0] ADDR_RATE_HI = 8'hAD;
  localparam logic [7:0] ADDR_WARM = 8'hAE;
  // field positions
  localparam int GW_LSB = 5;
  localparam int EDGE_LSB = 3;
  localparam int DIV_LSB = 0;
  localparam int PLL_WARM_LSB = 4;
  localparam int PA_WARM_LSB = 0;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FORCE_PA_BIT = 1;
  localparam int CTRL_FORCE_PLL_BIT = 2;
  localparam int CTRL_FORCE_LC_BIT = 3;
  localparam int CTRL_FSK_BIT = 4;
  localparam int CTRL_UNDERRUN_LSB = 6;
  localparam logic [7:0] CTRL_MASK = 8'hDF;
  localparam logic [7:0] RATE_HI_MASK = 8'h7F;
  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  // clock rates and cycle counts
  localparam int CLK_SYS_KHZ = 50000;
  localparam int REF_KHZ = 25000;
  localparam logic [2:0] REF_DIV_LIMIT = 3'(CLK_SYS_KHZ / REF_KHZ - 1);
  localparam logic [17:0] SYM_CLKS_PER_RATE = 18'h00005;
  localparam logic [3:0] RAMP_STEPS = 4'h8;
  localparam int PLL_WARM_SHIFT = 2;
  // holding buffer shape: width code plus one byte, two entries
  localparam int BUF_WIDTH = 11;
  localparam int BUF_DEPTH = 2;
  // underrun policies
  typedef enum logic [1:0] {
    UR_STOP = 2'h0,
    UR_REPEAT = 2'h1,
    UR_ZEROS = 2'h2,
    UR_ONES = 2'h3
  } underrun_t;
  // power sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WARM_PLL = 3'h1,
    ST_WARM_PA = 3'h2,
    ST_RAMP_UP = 3'h3,
    ST_SEND = 3'h4,
    ST_RAMP_DOWN = 3'h5
  } seq_state_t;
endpackage : ser_pkg

/* File: test_rf_output_symbol_serializer.sv */
// self-checking bench for the symbol serializer
`timescale 1ns/1ps
`default_nettype none
module test_rf_output_symbol_serializer;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic new_data_pulse, holding_empty, tx_symbol, tx_active, fsk_select;
  logic pa_ena, mpll_ena, lc_ena;
  logic [3:0] pa_ramp_level;
  int n_errors = 0;
  int cmp_count = 0;
  int r0;
  rf_output_symbol_serializer i_dut (.clk_sys(clk_sys), .resetn(resetn),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .new_data_pulse(new_data_pulse),
    .holding_empty(holding_empty), .tx_symbol(tx_symbol), .tx_active(tx_active),
    .fsk_select(fsk_select), .pa_ena(pa_ena), .pa_ramp_level(pa_ramp_level),
    .mpll_ena(mpll_ena), .lc_ena(lc_ena));
  rf_front_end_model i_rf (.clk_sys(clk_sys), .pa_ena(pa_ena),
    .pa_ramp_level(pa_ramp_level), .mpll_ena(mpll_ena), .lc_ena(lc_ena),
    .tx_symbol(tx_symbol));
  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
  endtask : rchk
  // holding write, then one pulse and a cleared empty flag
  task automatic put(input logic [7:0] d);
    int i;
    wr(ser_pkg::ADDR_HOLD, d);
    for (i = 0; i < 3 && new_data_pulse !== 1'b1; i++) @(negedge clk_sys);
    chk(new_data_pulse, 1);
    chk(holding_empty, 0);
    @(negedge clk_sys);
    chk(new_data_pulse, 0);
  endtask : put
  task automatic wait_tx(input logic lvl);
    int i;
    for (i = 0; i < 20000 && tx_active !== lvl; i++) @(negedge clk_sys);
    chk(tx_active, lvl);
  endtask : wait_tx
  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // watchdog against a hung sequencer
  initial
  begin
    #1ms;
    n_errors++;
    conclude;
  end
  initial
  begin
    repeat (3) @(negedge clk_sys);
    resetn = 1'b1;
    chk(holding_empty, 1);
    for (int a = 8'hAA; a <= 8'hAE; a++) rchk(8'(a), 8'h00);
    rchk(8'h10, 8'h00);
    wr(ser_pkg::ADDR_RATE_HI, 8'hFF);
    rchk(ser_pkg::ADDR_RATE_HI, 8'h7F);
    wr(ser_pkg::ADDR_RATE_LO, 8'hA5);
    rchk(ser_pkg::ADDR_RATE_LO, 8'hA5);
    $display("test registers done");
    // divider 3 keeps the serializer clock at 6.25 MHz
    wr(ser_pkg::ADDR_TIMING, 8'hEB);
    rchk(ser_pkg::ADDR_TIMING, 8'hEB);
    wr(ser_pkg::ADDR_WARM, 8'h23);
    rchk(ser_pkg::ADDR_WARM, 8'h23);
    wr(ser_pkg::ADDR_RATE_LO, 8'h02);
    wr(ser_pkg::ADDR_RATE_HI, 8'h00);
    wr(ser_pkg::ADDR_CTRL, 8'h10);
    chk(fsk_select, 1);
    r0 = i_rf.n_rise;
    put(8'h55);
    rchk(ser_pkg::ADDR_HOLD, 8'h55);
    repeat (200) @(negedge clk_sys);
    chk(tx_active, 0);
    wr(ser_pkg::ADDR_CTRL, 8'h11);
    wait_tx(1'b1);
    wait_tx(1'b0);
    chk(i_rf.n_rise - r0, 4);
    chk(i_rf.warm_span, 64);
    chk(i_rf.pa_to_tx, 152);
    chk(i_rf.sym_gap, 80);
    chk(i_rf.max_level, 8);
    chk(holding_empty, 1);
    $display("test single group done");
    r0 = i_rf.n_rise;
    wr(ser_pkg::ADDR_TIMING, 8'h2B);
    put(8'h55);
    wr(ser_pkg::ADDR_TIMING, 8'hEB);
    put(8'h55);
    wait_tx(1'b1);
    wait_tx(1'b0);
    chk(i_rf.n_rise - r0, 5);
    $display("test width change done");
    // repeat, zeros and ones after a two-symbol group 1,0
    for (int c = 1; c <= 3; c++)
    begin
      wr(ser_pkg::ADDR_TIMING, 8'h2B);
      wr(ser_pkg::ADDR_CTRL, {2'(c), 6'h11});
      r0 = i_rf.n_rise;
      put(8'h01);
      repeat (2000) @(negedge clk_sys);
      wr(ser_pkg::ADDR_CTRL, 8'h10);
      wait_tx(1'b0);
      r0 = i_rf.n_rise - r0;
      chk((c == 1) ? (r0 >= 3) : (r0 == c - 1), 1);
    end
    $display("test underrun done");
    // ook group 1,0,1: the zero-to-one step warms the rf up again
    wr(ser_pkg::ADDR_TIMING, 8'h4B);
    wr(ser_pkg::ADDR_CTRL, 8'h01);
    chk(fsk_select, 0);
    r0 = i_rf.n_rise;
    put(8'h05);
    wait_tx(1'b1);
    wait_tx(1'b0);
    chk(i_rf.n_rise - r0, 2);
    chk(i_rf.warm_span, 64);
    chk(i_rf.pa_to_tx, 152);
    chk(i_rf.bad, 0);
    $display("test ook done");
    conclude;
  end
endmodule : test_rf_output_symbol_serializer
`default_nettype wire

/* File: tick_divider.sv */
// enable-pulse divider: one tick every limit+1 qualifying cycles
`timescale 1ns/1ps
`default_nettype none
module tick_divider (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic en_in,
  input wire logic [2:0] limit,
  output logic tick
);
  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t s_r;
  div_state_t s_nxt;

  // count qualifying cycles and wrap at the limit
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (en_in)
    begin
      if (s_r.cnt >= limit)
      begin
        s_nxt.cnt = 3'h0;
        s_nxt.tick = 1'b1;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + 3'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick;
endmodule : tick_divider
`default_nettype wire
